// ---- design/css_device.sv ----
// Device end of the serial port with its registers.
// Assumes one clock; link pins are synchronised here.
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "css_cfg.svh"

// Operation
// [R1] External clock, handshake on: ready drives low.
// [R2] Ready returns high when reception begins.
// [R3] Internal clock: ready handshake has no effect.
// [R4] Cutoff enabled and low input: pins float.
// [R5] Polarity picks launch and sample edges.
// [R6] Partner idles external clock before start.
// [R7] Start needs enable, data, optional clear-to-send.
// [R8] Transmitter makes clock; dummy data shifts out.
// [R9] Internal clock: dummy write makes one frame.
// [R10] External clock: shifting follows partner edges only.
// [R11] Frame into full buffer sets overrun.
// [R12] Overrun leaves receive request flag unchanged.
// [R13] Software rewrites dummy byte every frame.
module css_device
    import css_pkg::*;
(
    input  wire logic        CORE_CLK,          // System clock.
    input  wire logic        RESETN,            // Asynchronous reset, active low.
    input  wire logic [7:0]  ADDR,              // Register byte address.
    input  wire logic [31:0] WDATA,             // Write data.
    input  wire logic        WR,                // Write strobe.
    input  wire logic        RD,                // Read strobe.
    output logic      [31:0] RDATA,             // Read data, cycle after RD.
    output logic             IRQ,               // Interrupt, active high level.
    input  wire logic        FORCED_CUTOFF_IN_N, // Forced cutoff pin, active low.
    css_link_if.dev          LINK               // Link to the partner.
);

    ////////////////////////////////////////////////////////////////////////////////
    css_dev_st_t st_r;   // Registered state.
    css_dev_st_t st_nxt; // Next state.
    logic        ext;    // External clock selected.
    logic        pol;    // Clock polarity.
    logic        cut;    // Forced cutoff active.
    logic [1:0]  edg;    // Link edge classes.
    logic        launch; // Launch edge this cycle.
    logic        sample; // Sample edge this cycle.
    logic        done;   // Frame complete this cycle.

    assign ext = st_r.ctrl[`CSS_CTRL_EXT];
    assign pol = st_r.ctrl[`CSS_CTRL_POL];
    // The cutoff pin is read only after its second flip-flop.
    assign cut = st_r.ctrl[`CSS_CTRL_CUT] && !st_r.sync[3]; // [R4]

    ////////////////////////////////////////////////////////////////////////////////
    // Next state of everything.
    always_comb begin
        st_nxt = st_r;
        launch = 1'b0;
        sample = 1'b0;
        done   = 1'b0;
        edg    = 2'b00;
        // Two-stage synchronisers.
        st_nxt.meta     = {FORCED_CUTOFF_IN_N, LINK.prt_sdo, LINK.cts_n, LINK.clk};
        st_nxt.sync     = st_r.meta;
        st_nxt.clk_prev = st_r.sync[0];

        // Reads answer a cycle later; unmapped give zero.
        st_nxt.rdata = 32'h0000_0000;
        if (RD) begin
            case (ADDR)
                `CSS_OFS_CTRL:   st_nxt.rdata = 32'(st_r.ctrl);
                `CSS_OFS_TXBUF:  st_nxt.rdata = 32'(st_r.txbuf);
                `CSS_OFS_RXBUF: begin
                    st_nxt.rdata   = 32'({st_r.ovr, st_r.rxbuf});
                    st_nxt.rx_full = 1'b0; // Reading drains the buffer.
                    st_nxt.ovr     = 1'b0;
                end
                `CSS_OFS_STATUS: st_nxt.rdata = 32'({st_r.rts, st_r.state == CSS_SHIFT, st_r.rx_full, st_r.tx_empty});
                `CSS_OFS_ISTAT:  st_nxt.rdata = 32'(st_r.istat);
                `CSS_OFS_IMASK:  st_nxt.rdata = 32'(st_r.imask);
                default: ;
            endcase
        end

        // Register writes; unmapped and read-only offsets are ignored.
        if (WR) begin
            case (ADDR)
                `CSS_OFS_CTRL:  st_nxt.ctrl = WDATA[5:0];
                `CSS_OFS_TXBUF: begin
                    // Each write, dummy or real, arms one frame.
                    st_nxt.txbuf    = WDATA[7:0]; // [R13]
                    st_nxt.tx_empty = 1'b0;
                end
                `CSS_OFS_ISTAT: st_nxt.istat = st_r.istat & ~WDATA[2:0];
                `CSS_OFS_IMASK: st_nxt.imask = WDATA[2:0];
                default: ;
            endcase
        end

        // Sequencer: the internal divider or partner edges produce every shift clock.
        case (st_r.state)
            CSS_IDLE: begin
                st_nxt.clk_o = ~pol;
                st_nxt.div   = 8'h00;
                // Start needs enable, data and, when enabled, clear-to-send.
                if (st_r.ctrl[`CSS_CTRL_TXEN] && !st_r.tx_empty &&
                    (!st_r.ctrl[`CSS_CTRL_CTS] || !st_r.sync[1])) begin // [R7]
                    st_nxt.state         = CSS_SHIFT;
                    st_nxt.started       = 1'b0;
                    st_nxt.tx_sh         = st_r.txbuf; // [R8]
                    st_nxt.bits          = 4'h0;
                    st_nxt.tx_empty      = 1'b1;
                    st_nxt.istat[`CSS_IRQ_TX] = 1'b1;
                end
            end
            CSS_SHIFT: begin
                if (!ext) begin
                    // Internal clock: divide down and toggle for one frame.
                    if (st_r.div == `CSS_HALF_CYC - 8'h01) begin // [R9]
                        st_nxt.div   = 8'h00;
                        st_nxt.clk_o = ~st_r.clk_o;
                        launch       = st_r.clk_o == ~pol;
                        sample       = st_r.clk_o == pol;
                    end else begin
                        st_nxt.div = st_r.div + 8'h01;
                    end
                end else begin
                    // External clock: move only on partner edges.
                    edg    = css_edge(pol, st_r.clk_prev, st_r.sync[0]);
                    launch = edg[1]; // [R10]
                    sample = edg[0] && st_r.started;
                end
                // Leaving idle level launches, returning to it samples.
                if (launch) begin // [R5]
                    st_nxt.started = 1'b1;
                    st_nxt.sdo     = st_r.tx_sh[0]; // [R8]
                    st_nxt.tx_sh   = {1'b0, st_r.tx_sh[7:1]};
                end
                if (sample) begin // [R5]
                    st_nxt.rx_sh = {st_r.sync[2], st_r.rx_sh[7:1]};
                    st_nxt.bits  = st_r.bits + 4'h1;
                    done         = st_r.bits == `CSS_FRAME_BITS - 4'h1;
                end
                if (done) begin
                    st_nxt.state = CSS_IDLE;
                    st_nxt.rxbuf = {st_r.sync[2], st_r.rx_sh[7:1]};
                    if (st_r.rx_full) begin
                        // Buffer now holds the new byte; request flag stays.
                        st_nxt.ovr                 = 1'b1; // [R11]
                        st_nxt.istat[`CSS_IRQ_OVR] = 1'b1; // [R12]
                    end else begin
                        st_nxt.rx_full            = 1'b1;
                        st_nxt.istat[`CSS_IRQ_RX] = 1'b1;
                    end
                end
            end
            default: st_nxt.state = CSS_IDLE;
        endcase

        // Dropping enable aborts a frame.
        if (!st_r.ctrl[`CSS_CTRL_TXEN]) begin
            st_nxt.state = CSS_IDLE;
        end

        // Ready is low only while armed for an external frame.
        st_nxt.rts = !(ext && st_r.ctrl[`CSS_CTRL_RTS] &&              // [R3]
                      st_nxt.state == CSS_SHIFT && !st_nxt.started);   // [R1] [R2]
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register; reset loads constants only.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_r          <= '0;
            st_r.meta     <= 4'hF;
            st_r.sync     <= 4'hF;
            st_r.clk_prev <= 1'b1;
            st_r.ctrl     <= `CSS_CTRL_RST;
            st_r.tx_empty <= 1'b1;
            st_r.istat    <= `CSS_IRQ_RST;
            st_r.imask    <= `CSS_IRQ_RST;
            st_r.clk_o    <= 1'b1;
            st_r.sdo      <= 1'b1;
            st_r.rts      <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pins. An idle clock follows polarity at once, so no stale edge shows.
    assign LINK.dev_clk_o    = (st_r.state == CSS_IDLE) ? ~pol : st_r.clk_o; // [R5]
    assign LINK.dev_clk_oe_n = ext || cut; // [R4]
    assign LINK.dev_sdo_o    = st_r.sdo;
    assign LINK.dev_sdo_oe_n = cut;        // [R4]
    assign LINK.dev_rts_o    = st_r.rts;
    assign LINK.dev_rts_oe_n = cut;        // [R4]
    assign RDATA             = st_r.rdata;
    assign IRQ               = |(st_r.istat & st_r.imask);

endmodule

// ---- design/css_cfg.svh ----
// Serial port constants: offsets, bits, resets, timing.
// Assumes inclusion by bare name.
`ifndef CSS_CFG_SVH
`define CSS_CFG_SVH

// Register byte offsets on the software port.
`define CSS_OFS_CTRL   8'h00
`define CSS_OFS_TXBUF  8'h04
`define CSS_OFS_RXBUF  8'h08
`define CSS_OFS_STATUS 8'h0C
`define CSS_OFS_ISTAT  8'h10
`define CSS_OFS_IMASK  8'h14

// Control register bit positions.
`define CSS_CTRL_TXEN  0
`define CSS_CTRL_EXT   1
`define CSS_CTRL_POL   2
`define CSS_CTRL_CTS   3
`define CSS_CTRL_RTS   4
`define CSS_CTRL_CUT   5

// Interrupt status and mask bit positions.
`define CSS_IRQ_RX     0
`define CSS_IRQ_TX     1
`define CSS_IRQ_OVR    2

// Receive buffer overrun bit position.
`define CSS_RXBUF_OVR  8

// Reset values.
`define CSS_CTRL_RST   6'h00
`define CSS_IRQ_RST    3'h0

// Timing: clock cycles per half period of a generated shift clock, and bits per frame.
`define CSS_HALF_CYC   8'h08
`define CSS_FRAME_BITS 4'h8

`endif

// ---- design/css_pkg.sv ----
// Serial port types and helpers.
// Assumes css_cfg.svh alongside.
`include "css_cfg.svh"

package css_pkg;

    // Transfer sequencer states.
    typedef enum logic {CSS_IDLE, CSS_SHIFT} css_state_t;

    // Whole state of the device end.
    typedef struct packed {
        logic [3:0]  meta;     // {cut, sdi, cts, clk}.
        logic [3:0]  sync;     // Stage 2.
        logic        clk_prev; // Old clock.
        logic [5:0]  ctrl;     // Control.
        logic [7:0]  txbuf;    // Tx byte.
        logic        tx_empty; // Tx empty.
        logic [7:0]  rxbuf;    // Rx byte.
        logic        rx_full;  // Rx full.
        logic        ovr;      // Overrun.
        logic [2:0]  istat;    // Status.
        logic [2:0]  imask;    // Mask.
        css_state_t  state;    // State.
        logic        started;  // Launched.
        logic [7:0]  tx_sh;    // Tx shift.
        logic [7:0]  rx_sh;    // Rx shift.
        logic [3:0]  bits;     // Bit count.
        logic [7:0]  div;      // Divider.
        logic        clk_o;    // Clock out.
        logic        sdo;      // Data out.
        logic        rts;      // Ready out.
        logic [31:0] rdata;    // Read data.
    } css_dev_st_t;

    // Whole state of the partner end.
    typedef struct packed {
        logic [2:0]  meta;     // {rts, sdi, clk}.
        logic [2:0]  sync;     // Stage 2.
        logic        clk_prev; // Old clock.
        css_state_t  state;    // State.
        logic        started;  // Running.
        logic [7:0]  tx_sh;    // Tx shift.
        logic [7:0]  rx_sh;    // Rx shift.
        logic [3:0]  bits;     // Bit count.
        logic [7:0]  div;      // Divider.
        logic        clk_o;    // Clock out.
        logic        sdo;      // Data out.
        logic [7:0]  rx_data;  // Rx byte.
        logic        rx_valid; // Rx pulse.
    } css_prt_st_t;

    // Classifies a clock change as {launch, sample}; idle level is ~pol.
    function automatic logic [1:0] css_edge(input logic pol, input logic prev, input logic cur);
        css_edge = {prev == ~pol && cur == pol, prev == pol && cur == ~pol};
    endfunction

endpackage

// ---- design/css_link_if.sv ----
// Link between device and partner.
// Assumes each end drives its own outputs; wires resolve here.
`timescale 1ns/1ps

interface css_link_if;
    logic dev_clk_o;    // Device clock.
    logic dev_clk_oe_n; // Its enable.
    logic prt_clk_o;    // Partner clock.
    logic prt_clk_oe_n; // Its enable.
    logic clk;          // Clock pin.
    logic dev_sdo_o;    // Device data.
    logic dev_sdo_oe_n; // Its enable.
    logic sdo;          // Data wire.
    logic prt_sdo;      // Partner data.
    logic dev_rts_o;    // Ready.
    logic dev_rts_oe_n; // Its enable.
    logic rts;          // Ready wire.
    logic cts_n;        // Clear to send.

    // Undriven wires float high through a pull-up.
    assign clk = !dev_clk_oe_n ? dev_clk_o : (!prt_clk_oe_n ? prt_clk_o : 1'b1);
    assign sdo = !dev_sdo_oe_n ? dev_sdo_o : 1'b1;
    assign rts = !dev_rts_oe_n ? dev_rts_o : 1'b1;

    modport dev (output dev_clk_o, dev_clk_oe_n, dev_sdo_o, dev_sdo_oe_n, dev_rts_o, dev_rts_oe_n,
                 input clk, prt_sdo, cts_n);
    modport prt (output prt_clk_o, prt_clk_oe_n, prt_sdo, cts_n, input clk, sdo, rts);
endinterface

// ---- design/css_partner.sv ----
// Partner end: an external synchronous transmitter and receiver.
// Assumes one clock; device pins are synchronised here.
`timescale 1ns/1ps
`include "css_cfg.svh"

module css_partner
    import css_pkg::*;
(
    input  wire logic       CORE_CLK,      // System clock.
    input  wire logic       RESETN,        // Asynchronous reset, active low.
    input  wire logic       CLK_SUPPLY,    // 1: this end makes the transfer clock.
    input  wire logic       POLARITY,      // Clock polarity, same as device.
    input  wire logic       USE_HANDSHAKE, // 1: wait for device ready low.
    input  wire logic       RX_HOLD,       // 1: hold clear-to-send high.
    input  wire logic [7:0] TX_DATA,       // Byte to send.
    input  wire logic       TX_VALID,      // Byte offered.
    output logic            TX_READY,      // Byte taken when valid.
    output logic      [7:0] RX_DATA,       // Last byte received.
    output logic            RX_VALID,      // One-cycle pulse with RX_DATA.
    css_link_if.prt         LINK           // Link to the device.
);

    ////////////////////////////////////////////////////////////////////////////////
    css_prt_st_t st_r;   // Registered state.
    css_prt_st_t st_nxt; // Next state.
    logic [1:0]  edg;    // Link edge classes.
    logic        launch; // Launch edge this cycle.
    logic        sample; // Sample edge this cycle.

    assign TX_READY = st_r.state == CSS_IDLE;

    ////////////////////////////////////////////////////////////////////////////////
    // Next state, either clock role.
    always_comb begin
        st_nxt          = st_r;
        launch          = 1'b0;
        sample          = 1'b0;
        edg             = 2'b00;
        st_nxt.meta     = {LINK.rts, LINK.sdo, LINK.clk};
        st_nxt.sync     = st_r.meta;
        st_nxt.clk_prev = st_r.sync[0];
        st_nxt.rx_valid = 1'b0;
        case (st_r.state)
            CSS_IDLE: begin
                // Hold idle level before any start.
                st_nxt.clk_o = ~POLARITY; // [R6]
                st_nxt.div   = 8'h00;
                if (TX_VALID) begin
                    st_nxt.state   = CSS_SHIFT;
                    st_nxt.started = 1'b0;
                    st_nxt.tx_sh   = TX_DATA;
                    st_nxt.bits    = 4'h0;
                end
            end
            CSS_SHIFT: begin
                if (CLK_SUPPLY) begin
                    // With handshake on, clock only once the device is ready.
                    if (st_r.started || !USE_HANDSHAKE || !st_r.sync[2]) begin // [R10]
                        st_nxt.started = 1'b1;
                        if (st_r.div == `CSS_HALF_CYC - 8'h01) begin
                            st_nxt.div   = 8'h00;
                            st_nxt.clk_o = ~st_r.clk_o;
                            launch       = st_r.clk_o == ~POLARITY;
                            sample       = st_r.clk_o == POLARITY;
                        end else begin
                            st_nxt.div = st_r.div + 8'h01;
                        end
                    end
                end else begin
                    // The device makes every edge.
                    edg    = css_edge(POLARITY, st_r.clk_prev, st_r.sync[0]); // [R8]
                    launch = edg[1];
                    sample = edg[0];
                end
                if (launch) begin
                    st_nxt.sdo   = st_r.tx_sh[0];
                    st_nxt.tx_sh = {1'b0, st_r.tx_sh[7:1]};
                end
                if (sample) begin
                    st_nxt.rx_sh = {st_r.sync[1], st_r.rx_sh[7:1]};
                    st_nxt.bits  = st_r.bits + 4'h1;
                    if (st_r.bits == `CSS_FRAME_BITS - 4'h1) begin
                        st_nxt.state    = CSS_IDLE;
                        st_nxt.rx_data  = {st_r.sync[1], st_r.rx_sh[7:1]};
                        st_nxt.rx_valid = 1'b1;
                    end
                end
            end
            default: st_nxt.state = CSS_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register; reset loads constants only.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_r          <= '0;
            st_r.meta     <= 3'h7;
            st_r.sync     <= 3'h7;
            st_r.clk_prev <= 1'b1;
            st_r.clk_o    <= 1'b1;
            st_r.sdo      <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign LINK.prt_clk_o    = st_r.clk_o;
    assign LINK.prt_clk_oe_n = !CLK_SUPPLY;
    assign LINK.prt_sdo      = st_r.sdo;
    assign LINK.cts_n        = RX_HOLD;
    assign RX_DATA           = st_r.rx_data;
    assign RX_VALID          = st_r.rx_valid;

endmodule

// ---- bench/css_props.sv ----
// Concurrent checks on the link.
// Assumes inputs wired from the link interface.
`timescale 1ns/1ps

module css_props (
    input wire logic CORE_CLK,     // System clock.
    input wire logic RESETN,       // Reset, active low.
    input wire logic clk,          // Resolved transfer clock.
    input wire logic sdo,          // Resolved device data.
    input wire logic rts,          // Resolved receive ready.
    input wire logic cts_n,        // Clear to send, active low.
    input wire logic dev_clk_oe_n, // Device clock enable.
    input wire logic dev_sdo_oe_n, // Device data enable.
    input wire logic dev_rts_oe_n, // Ready enable.
    input wire logic prt_clk_oe_n  // Partner clock enable.
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);

    ////////////////////////////////////////////////////////////////////////////////
    // Cutoff floats all device pins together.
    chk_cut_float: assert property (dev_sdo_oe_n |-> dev_rts_oe_n && dev_clk_oe_n)
        else $error("cutoff left a link pin driven");
    // A generated clock keeps its half period.
    chk_clk_pace: assert property (!dev_clk_oe_n && $changed(clk) |=> $stable(clk) [*6])
        else $error("generated clock half period too short");
    // Data moves only with a device clock edge.
    chk_sdo_launch: assert property (!dev_clk_oe_n && !dev_sdo_oe_n && !$past(dev_sdo_oe_n)
        && $changed(sdo) |-> $changed(clk)) else $error("data changed away from a clock edge");
    // Ready falls only in external mode, then holds.
    chk_rts_arm: assert property ($fell(rts) |-> dev_clk_oe_n ##1 !rts [*3])
        else $error("ready low outside external mode or too short");
    // Ready rises soon after the first edge.
    chk_rts_rise: assert property (!rts && $changed(clk) |-> ##[1:5] rts)
        else $error("ready stayed low after reception began");
    // An internally clocked channel never shows ready low.
    chk_rts_int: assert property (!dev_clk_oe_n |-> rts)
        else $error("ready low with internal clock");
    // A held clear-to-send keeps the clock still.
    chk_cts_block: assert property (cts_n [*4] |-> $stable(clk))
        else $error("clock moved while clear-to-send held");
    // Only one end ever drives the clock.
    chk_one_clk: assert property (!dev_clk_oe_n |-> prt_clk_oe_n)
        else $error("both ends drive the transfer clock");

    cover property ($fell(rts));
    cover property (cts_n [*4]);
    cover property (dev_sdo_oe_n);
endmodule

// ---- bench/testbench.sv ----
// Bench: both ends on one link, registers and partner driven.
// Assumes the design files are compiled first.
`timescale 1ns/1ps
`include "css_cfg.svh"

module testbench;
    import css_pkg::*;
    typedef struct {logic [31:0] e; logic [31:0] m; string n;} css_exp_t; // Pending read result.
    logic        CORE_CLK      = 1'h0;  // System clock.
    logic        RESETN        = 1'h0;  // Reset, active low.
    logic [7:0]  ADDR          = 8'h00; // Register address.
    logic [31:0] WDATA         = 32'h0; // Write data.
    logic        WR            = 1'h0;  // Write strobe.
    logic        RD            = 1'h0;  // Read strobe.
    logic [31:0] RDATA;                 // Read data.
    logic        IRQ;                   // Interrupt level.
    logic        CUT_N         = 1'h1;  // Forced cutoff pin.
    logic        CLK_SUPPLY    = 1'h0;  // Partner makes the clock.
    logic        POLARITY      = 1'h0;  // Partner clock polarity.
    logic        USE_HANDSHAKE = 1'h0;  // Partner waits for ready.
    logic        RX_HOLD       = 1'h0;  // Partner holds clear-to-send.
    logic [7:0]  TX_DATA       = 8'h00; // Partner byte.
    logic        TX_VALID      = 1'h0;  // Partner byte offered.
    logic        TX_READY;              // Partner idle.
    logic [7:0]  RX_DATA;               // Partner received byte.
    logic        RX_VALID;              // Partner receive pulse.
    logic        rd_d          = 1'h0;  // Read strobe one cycle late.
    css_exp_t    q[$];                  // Expected read results.
    css_exp_t    cur;                   // Read result under test.
    logic [7:0]  qx[$];                 // Bytes the partner should receive.
    int          fails         = 0;     // Mismatches.
    int          n_checks      = 0;     // Comparisons.

    css_link_if link ();
    css_device u_css_device (.CORE_CLK, .RESETN, .ADDR, .WDATA, .WR, .RD, .RDATA, .IRQ,
        .FORCED_CUTOFF_IN_N(CUT_N), .LINK(link));
    css_partner u_css_partner (.CORE_CLK, .RESETN, .CLK_SUPPLY, .POLARITY, .USE_HANDSHAKE, .RX_HOLD,
        .TX_DATA, .TX_VALID, .TX_READY, .RX_DATA, .RX_VALID, .LINK(link));
    css_props u_css_props (.CORE_CLK, .RESETN, .clk(link.clk), .sdo(link.sdo),
        .rts(link.rts), .cts_n(link.cts_n), .dev_clk_oe_n(link.dev_clk_oe_n),
        .dev_sdo_oe_n(link.dev_sdo_oe_n), .dev_rts_oe_n(link.dev_rts_oe_n), .prt_clk_oe_n(link.prt_clk_oe_n));

    // A 25 MHz system clock.
    always #20 CORE_CLK = ~CORE_CLK;

    ////////////////////////////////////////////////////////////////////////////////
    // Counts one compare and reports a difference.
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    // Counts, verdict, end of run.
    task automatic results;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One-cycle register write.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CORE_CLK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'h1;
        @(posedge CORE_CLK);
        WR    <= 1'h0;
    endtask

    // One-cycle read; the monitor compares it masked.
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string n);
        @(posedge CORE_CLK);
        q.push_back('{e, m, n});
        ADDR <= a;
        RD   <= 1'h1;
        @(posedge CORE_CLK);
        RD   <= 1'h0;
    endtask

    // Offers a byte; ready seen before an edge means it is taken there.
    task automatic offer(input logic [7:0] b);
        @(posedge CORE_CLK);
        TX_DATA  <= b;
        TX_VALID <= 1'h1;
        for (int i = 0; i < 3000 && TX_READY !== 1'h1; i++) @(negedge CORE_CLK);
        if (TX_READY !== 1'h1) begin
            chk("offer wait", 32'h0, 32'h1);
            results();
        end
        @(posedge CORE_CLK);
        TX_VALID <= 1'h0;
    endtask

    // Bounded wait for the interrupt.
    task automatic wait_irq;
        for (int i = 0; i < 3000; i++) begin
            @(posedge CORE_CLK);
            if (IRQ === 1'h1) return;
        end
        chk("irq wait", 32'h0, 32'h1);
        results();
    endtask

    // One full-duplex frame, first held by clear-to-send if asked.
    task automatic xfer(input logic hold);
        logic [7:0] a;
        logic [7:0] b;
        a = 8'($urandom);
        b = 8'($urandom);
        offer(b);
        qx.push_back(a);
        wr(`CSS_OFS_TXBUF, {24'h0, a});
        if (hold) begin
            repeat (100) @(posedge CORE_CLK);
            rd(`CSS_OFS_STATUS, 32'h8, 32'hF, "held status");
            RX_HOLD <= 1'h0;
        end
        wait_irq();
        rd(`CSS_OFS_RXBUF, {24'h0, b}, 32'h1FF, "rx byte");
        rd(`CSS_OFS_ISTAT, 32'h3, 32'h7, "istat frame");
        wr(`CSS_OFS_ISTAT, 32'h7);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Falling-edge sampling keeps clear of the update edge.
    always @(posedge CORE_CLK) rd_d <= RD;
    always @(negedge CORE_CLK) begin
        if (rd_d) begin
            cur = q.size() ? q.pop_front() : '{32'hX, 32'hFFFFFFFF, "read queue"};
            chk(cur.n, RDATA & cur.m, cur.e & cur.m);
        end
        if (RX_VALID === 1'h1) begin
            chk("partner rx", {24'h0, RX_DATA}, qx.size() ? {24'h0, qx.pop_front()} : 32'hX);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        void'($urandom(67));
        repeat (3) @(posedge CORE_CLK);
        RESETN <= 1'h1;
        rd(`CSS_OFS_CTRL, 32'h0, 32'h3F, "ctrl reset");
        rd(`CSS_OFS_IMASK, 32'h0, 32'h7, "imask reset");
        rd(8'h18, 32'h0, 32'hFFFFFFFF, "unmapped");
        wr(`CSS_OFS_IMASK, 32'h1);
        // Both clock sources and polarities; the device lets go of the clock first.
        for (int m = 0; m < 4; m++) begin
            wr(`CSS_OFS_CTRL, {27'h0, m[1], 1'h0, m[0], m[1], 1'h1});
            repeat (2) @(posedge CORE_CLK);
            CLK_SUPPLY    <= m[1];
            USE_HANDSHAKE <= m[1];
            POLARITY      <= m[0];
            xfer(1'h0);
        end
        // Overrun: the second frame lands on an unread buffer.
        CLK_SUPPLY    <= 1'h0;
        USE_HANDSHAKE <= 1'h0;
        POLARITY      <= 1'h0;
        repeat (2) @(posedge CORE_CLK);
        wr(`CSS_OFS_CTRL, 32'h1);
        wr(`CSS_OFS_IMASK, 32'h4);
        offer(8'h3C);
        qx.push_back(8'hC3);
        wr(`CSS_OFS_TXBUF, 32'hC3);
        repeat (200) @(posedge CORE_CLK);
        chk("masked irq", {31'h0, IRQ}, 32'h0);
        wr(`CSS_OFS_ISTAT, 32'h7);
        offer(8'h5A);
        qx.push_back(8'hA5);
        wr(`CSS_OFS_TXBUF, 32'hA5);
        wait_irq();
        rd(`CSS_OFS_ISTAT, 32'h6, 32'h7, "istat overrun");
        rd(`CSS_OFS_RXBUF, 32'h100, 32'h100, "overrun flag");
        rd(`CSS_OFS_RXBUF, 32'h0, 32'h100, "overrun cleared");
        wr(`CSS_OFS_ISTAT, 32'h7);
        @(negedge CORE_CLK);
        chk("irq cleared", {31'h0, IRQ}, 32'h0);
        // Held clear-to-send stalls a frame.
        wr(`CSS_OFS_IMASK, 32'h1);
        RX_HOLD <= 1'h1;
        wr(`CSS_OFS_CTRL, 32'h9);
        xfer(1'h1);
        // Cutoff floats the pins; release restores them.
        wr(`CSS_OFS_CTRL, 32'h20);
        CUT_N <= 1'h0;
        repeat (6) @(negedge CORE_CLK);
        chk("cut oe", {29'h0, link.dev_clk_oe_n, link.dev_sdo_oe_n, link.dev_rts_oe_n}, 32'h7);
        CUT_N <= 1'h1;
        repeat (6) @(negedge CORE_CLK);
        chk("drive oe", {29'h0, link.dev_clk_oe_n, link.dev_sdo_oe_n, link.dev_rts_oe_n}, 32'h0);
        chk("rx left", 32'(qx.size()), 32'h0);
        results();
    end
endmodule
